// file: design/flash_cmd_pkg.sv
package flash_cmd_pkg;

  // ----------------------------------------
  // Opcodes
  // ----------------------------------------
  localparam logic [7:0] NOP_CMD              = 8'h00;
  localparam logic [7:0] RESET_ARM_CMD        = 8'h66;
  localparam logic [7:0] RESET_EXEC_CMD       = 8'h99;
  localparam logic [7:0] PARAM_TABLE_READ_CMD = 8'h5A;

  // ----------------------------------------
  // Bit counts and lane widths
  // ----------------------------------------
  localparam logic [4:0] OPC_BITS   = 5'h08;
  localparam logic [4:0] ADDR_BITS  = 5'h18;
  localparam logic [4:0] DUMMY_BITS = 5'h08;
  localparam logic [4:0] LANE_ONE   = 5'h01;
  localparam logic [4:0] LANE_FOUR  = 5'h04;
  localparam logic [4:0] CNT_ZERO   = 5'h00;
  localparam logic [3:0] OUT_ONE    = 4'h1;
  localparam logic [3:0] OUT_FOUR   = 4'h4;
  localparam logic [3:0] BYTE_BITS  = 4'h8;
  localparam logic [3:0] OE_ALL_OFF = 4'hF;
  localparam logic [3:0] OE_SINGLE  = 4'hD;   // Only the output line driven
  localparam logic [3:0] OE_QUAD    = 4'h0;
  localparam logic [3:0] SIO_IDLE   = 4'h0;
  localparam logic [23:0] ADDR_ONE  = 24'h00_0001;

  // ----------------------------------------
  // Recovery timing
  // ----------------------------------------
  localparam int CLK_PERIOD_NS   = 10;
  localparam int RECOV_PGM_NS    = 40000;
  localparam int RECOV_OTHER_NS  = 12000;
  localparam int RECOV_PGM_INT   = (RECOV_PGM_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RECOV_OTHER_INT = (RECOV_OTHER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [11:0] RECOV_PGM_CYC   = RECOV_PGM_INT[11:0];
  localparam logic [11:0] RECOV_OTHER_CYC = RECOV_OTHER_INT[11:0];
  localparam logic [11:0] RECOV_ZERO      = 12'h000;
  localparam logic [11:0] RECOV_STEP      = 12'h001;

  // ----------------------------------------
  // Parameter header table
  // ----------------------------------------
  localparam int         HDR_LEN  = 24;
  localparam logic [7:0] HDR_MFR_ADDR = 8'h10;
  localparam logic [7:0] HDR_FILL = 8'hFF;
  localparam logic [7:0] HDR_BYTES [HDR_LEN] = '{
    8'h53, 8'h46, 8'h44, 8'h50, 8'h00, 8'h01, 8'h01, 8'hFF,
    8'h00, 8'h00, 8'h01, 8'h09, 8'h30, 8'h00, 8'h00, 8'hFF,
    8'hFF, 8'h00, 8'h01, 8'h04, 8'h60, 8'h00, 8'h00, 8'hFF};

  // ----------------------------------------
  // Link pins and state
  // ----------------------------------------
  typedef struct packed {
    logic       cs_n;
    logic       sclk;
    logic [3:0] sio;
  } link_pins_t;

  typedef enum logic [2:0] {
    PH_IDLE  = 3'b000,
    PH_OPC   = 3'b001,
    PH_ADDR  = 3'b011,
    PH_DUMMY = 3'b010,
    PH_DATA  = 3'b110,
    PH_SKIP  = 3'b111
  } phase_t;

  typedef struct packed {
    phase_t      phase;
    logic [4:0]  cnt;
    logic [23:0] sh_in;
    logic [7:0]  opcode;
    logic [23:0] addr;
    logic [7:0]  sh_out;
    logic [3:0]  out_left;
    logic        arm;
    logic [11:0] recov;
    logic        busy;
    logic        standby;
    logic        soft_rst;
    logic        abort;
    logic [3:0]  sio_out;
    logic [3:0]  sio_oe_n;
  } ctl_t;

endpackage

// file: design/pin_sampler.sv
`timescale 1ns/10ps
module pin_sampler
  import flash_cmd_pkg::*;
#(
  parameter int W = 6
) (
  input  wire logic         ref_clk_in,
  input  wire logic         rst_in,
  input  wire logic [W-1:0] raw_in,
  output logic [W-1:0]      level_out,
  output logic [W-1:0]      rise_out,
  output logic [W-1:0]      fall_out
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] lvl;
    logic [W-1:0] prev;
  } samp_t;

  samp_t        q;
  samp_t        d;
  logic [W-1:0] lvl_next;

  // ----------------------------------------
  // Per-bit filter: accept when stages two and three agree
  // ----------------------------------------
  for (genvar i = 0; i < W; i++) begin : g_bit
    assign lvl_next[i] = (q.s2[i] == q.s3[i]) ? q.s3[i] : q.lvl[i];
  end

  // Next state
  always_comb begin
    d      = q;
    d.s1   = raw_in;
    d.s2   = q.s1;
    d.s3   = q.s2;
    d.lvl  = lvl_next;
    d.prev = q.lvl;
  end

  // Registers; idle link is all ones
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      q <= '1;
    end else begin
      q <= d;
    end
  end

  assign level_out = q.lvl;
  assign rise_out  = q.lvl & ~q.prev;
  assign fall_out  = ~q.lvl & q.prev;

endmodule

// file: design/param_header_rom.sv
`timescale 1ns/10ps
module param_header_rom
  import flash_cmd_pkg::*;
#(
  parameter logic [7:0] MFR_ID = 8'h3E   // Arbitrary maker code
) (
  input  wire logic [23:0] addr_in,
  output logic [7:0]       data_out
);

  // ----------------------------------------
  // Header lookup, fill beyond the table
  // ----------------------------------------
  always_comb begin
    if (addr_in >= 24'(HDR_LEN)) begin
      data_out = HDR_FILL;
    end else if (addr_in[7:0] == HDR_MFR_ADDR) begin
      data_out = MFR_ID;
    end else begin
      data_out = HDR_BYTES[addr_in[4:0]];
    end
  end

endmodule

// file: design/flash_cmd_core.sv
`timescale 1ns/10ps
module flash_cmd_core
  import flash_cmd_pkg::*;
(
  input  wire logic       ref_clk_in,
  input  wire logic       rst_in,
  input  wire logic       link_cs_n_in,
  input  wire logic       link_sclk_in,
  input  wire logic [3:0] link_sio_in,
  input  wire logic       four_line_command_mode_in,
  input  wire logic       program_busy_in,
  input  wire logic       erase_busy_in,
  output logic [3:0]      link_sio_out,
  output logic [3:0]      link_sio_oe_n_out,
  output logic            soft_reset_out,
  output logic            op_abort_out,
  output logic            recovery_busy_out,
  output logic            standby_out
);

  // ----------------------------------------
  // Link sampling
  // ----------------------------------------
  link_pins_t pins_raw;
  link_pins_t pins_lvl;
  link_pins_t pins_rise;
  link_pins_t pins_fall;
  logic [7:0] rom_byte;
  ctl_t       q;
  ctl_t       d;
  logic [23:0] sh_next;
  logic [4:0]  lane;
  logic [4:0]  cnt_next;
  logic        cs_end;
  logic        exact_cmd;

  assign pins_raw = '{cs_n: link_cs_n_in, sclk: link_sclk_in, sio: link_sio_in};

  pin_sampler #(
    .W ($bits(link_pins_t))
  ) u_sampler (
    .ref_clk_in (ref_clk_in),
    .rst_in     (rst_in),
    .raw_in     (pins_raw),
    .level_out  (pins_lvl),
    .rise_out   (pins_rise),
    .fall_out   (pins_fall)
  );

  param_header_rom u_rom (
    .addr_in  (q.addr),
    .data_out (rom_byte)
  );

  // Input shift per edge, upper lines ignored in single-line mode
  always_comb begin
    if (four_line_command_mode_in) begin
      sh_next = {q.sh_in[19:0], pins_lvl.sio};
      lane    = LANE_FOUR;
    end else begin
      sh_next = {q.sh_in[22:0], pins_lvl.sio[0]};
      lane    = LANE_ONE;
    end
    cnt_next  = q.cnt + lane;
    cs_end    = pins_rise.cs_n;
    exact_cmd = (q.phase == PH_SKIP) && (q.cnt == CNT_ZERO);
  end

  // ----------------------------------------
  // Command sequencer
  // ----------------------------------------
  always_comb begin
    d          = q;
    d.soft_rst = 1'b0;
    d.abort    = 1'b0;
    if (q.recov != RECOV_ZERO) begin
      d.recov = q.recov - RECOV_STEP;
    end
    if (cs_end) begin
      // Frame end: execute exact one-byte commands, stop output
      if (exact_cmd) begin
        if (q.opcode == RESET_ARM_CMD) begin
          d.arm = 1'b1;
        end else if (q.opcode == RESET_EXEC_CMD && q.arm) begin
          d.arm      = 1'b0;
          d.soft_rst = 1'b1;
          d.abort    = program_busy_in | erase_busy_in;
          d.recov    = program_busy_in ? RECOV_PGM_CYC : RECOV_OTHER_CYC;
        end else begin
          d.arm = 1'b0;
        end
      end else if (q.phase != PH_IDLE) begin
        d.arm = 1'b0;
      end
      d.phase    = PH_IDLE;
      d.sio_oe_n = OE_ALL_OFF;
      d.sio_out  = SIO_IDLE;
    end else if (pins_fall.cs_n) begin
      d.cnt      = q.busy ? LANE_ONE : CNT_ZERO;
      d.phase    = q.busy ? PH_SKIP : PH_OPC;
      d.out_left = OUT_ONE - OUT_ONE;
    end else if (pins_rise.sclk && !pins_lvl.cs_n) begin
      d.sh_in = sh_next;
      d.cnt   = cnt_next;
      case (q.phase)
        PH_OPC: begin
          if (cnt_next == OPC_BITS) begin
            d.opcode = sh_next[7:0];
            d.cnt    = CNT_ZERO;
            d.phase  = (sh_next[7:0] == PARAM_TABLE_READ_CMD) ? PH_ADDR : PH_SKIP;
          end
        end
        PH_ADDR: begin
          if (cnt_next == ADDR_BITS) begin
            d.addr  = sh_next;
            d.cnt   = CNT_ZERO;
            d.phase = PH_DUMMY;
          end
        end
        PH_DUMMY: begin
          if (cnt_next == DUMMY_BITS) begin
            d.cnt   = CNT_ZERO;
            d.phase = PH_DATA;
          end
        end
        PH_SKIP: begin
          d.cnt = LANE_ONE;   // Extra clocks spoil the byte boundary
        end
        PH_DATA: begin
          d.cnt = CNT_ZERO;
        end
        default: begin
          d.cnt = q.cnt;
        end
      endcase
    end else if (pins_fall.sclk && !pins_lvl.cs_n && q.phase == PH_DATA) begin
      // Data out on falling edges, MSB first
      if (q.out_left == SIO_IDLE) begin
        d.addr = q.addr + ADDR_ONE;
        if (four_line_command_mode_in) begin
          d.sio_out  = rom_byte[7:4];
          d.sh_out   = {rom_byte[3:0], 4'h0};
          d.out_left = BYTE_BITS - OUT_FOUR;
          d.sio_oe_n = OE_QUAD;
        end else begin
          d.sio_out  = {2'b00, rom_byte[7], 1'b0};
          d.sh_out   = {rom_byte[6:0], 1'b0};
          d.out_left = BYTE_BITS - OUT_ONE;
          d.sio_oe_n = OE_SINGLE;
        end
      end else if (four_line_command_mode_in) begin
        d.sio_out  = q.sh_out[7:4];
        d.sh_out   = {q.sh_out[3:0], 4'h0};
        d.out_left = q.out_left - OUT_FOUR;
      end else begin
        d.sio_out  = {2'b00, q.sh_out[7], 1'b0};
        d.sh_out   = {q.sh_out[6:0], 1'b0};
        d.out_left = q.out_left - OUT_ONE;
      end
    end
    d.busy    = (d.recov != RECOV_ZERO);
    d.standby = (d.phase == PH_IDLE) && !d.busy;
  end

  // State register, power-on defaults
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      q          <= '0;
      q.sio_oe_n <= OE_ALL_OFF;
      q.standby  <= 1'b1;
    end else if (q.soft_rst) begin
      q          <= '0;
      q.sio_oe_n <= OE_ALL_OFF;
      q.recov    <= d.recov;
      q.busy     <= 1'b1;
      q.standby  <= 1'b0;
    end else begin
      q <= d;
    end
  end

  assign link_sio_out      = q.sio_out;
  assign link_sio_oe_n_out = q.sio_oe_n;
  assign soft_reset_out    = q.soft_rst;
  assign op_abort_out      = q.abort;
  assign recovery_busy_out = q.busy;
  assign standby_out       = q.standby;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  a_nop_no_reset: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    cs_end && exact_cmd && q.opcode == NOP_CMD |=> !q.soft_rst && !q.arm)
    else $error("nop caused reset or kept arm");

  a_exec_needs_arm: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    $rose(q.soft_rst) |-> $past(q.arm))
    else $error("reset executed without arm");

  a_arm_cancelled: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    cs_end && !(exact_cmd && q.opcode == RESET_ARM_CMD) |=> !q.arm)
    else $error("arm survived another command");

  a_reset_standby: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    q.soft_rst |=> q.busy && q.phase == PH_IDLE && !q.arm)
    else $error("reset did not return to idle");

  a_abort_on_busy: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    cs_end && exact_cmd && q.arm && q.opcode == RESET_EXEC_CMD
    && (program_busy_in || erase_busy_in) |=> q.abort && q.soft_rst)
    else $error("busy operation not aborted");

  a_pgm_recovery: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    cs_end && exact_cmd && q.arm && q.opcode == RESET_EXEC_CMD && program_busy_in
    |=> ##1 q.recov == RECOV_PGM_CYC - RECOV_STEP)
    else $error("program recovery count wrong");

  a_cs_stops_out: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    cs_end |=> q.sio_oe_n == OE_ALL_OFF [*2])
    else $error("output driven after chip select high");

  a_single_lines: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    !four_line_command_mode_in && q.sio_oe_n != OE_ALL_OFF |-> q.sio_oe_n == OE_SINGLE)
    else $error("extra lines driven in single mode");

  a_read_phases: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    $changed(q.phase) && q.phase == PH_DATA |-> $past(q.phase) == PH_DUMMY
    && q.opcode == PARAM_TABLE_READ_CMD)
    else $error("data phase without read sequence");

  a_header_count: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    q.addr == 24'h00_0006 |-> rom_byte == 8'h01)
    else $error("header count byte wrong");

  // Execute without arm is dropped, a clean arm is latched
  a_exec_ignored: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    cs_end && exact_cmd && q.opcode == RESET_EXEC_CMD && !q.arm |=> !q.soft_rst)
    else $error("unarmed execute caused reset");

  a_arm_taken: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    cs_end && exact_cmd && q.opcode == RESET_ARM_CMD && !q.soft_rst |=> q.arm)
    else $error("arm command not latched");

  // Reset pulse lasts one cycle and leaves cleared state behind
  a_reset_pulse: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    q.soft_rst |=> !q.soft_rst && q.cnt == CNT_ZERO && q.sio_oe_n == OE_ALL_OFF)
    else $error("reset pulse or cleared state wrong");

  a_abort_paired: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    q.abort |-> q.soft_rst)
    else $error("abort without reset");

  // Short recovery when no program was running
  a_other_recovery: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    cs_end && exact_cmd && q.arm && q.opcode == RESET_EXEC_CMD && !program_busy_in
    |=> ##1 q.recov == RECOV_OTHER_CYC - RECOV_STEP)
    else $error("other recovery count wrong");

  // Frames opened during recovery are skipped whole
  a_busy_skips: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    pins_fall.cs_n && q.busy && !q.soft_rst |=> q.phase == PH_SKIP)
    else $error("frame accepted during recovery");

  // Byte start: top bit or nibble on the right lines, address steps on
  a_single_first: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    pins_fall.sclk && !pins_lvl.cs_n && q.phase == PH_DATA && !q.soft_rst
    && q.out_left == '0 && !four_line_command_mode_in
    |=> q.sio_out[1] == $past(rom_byte[7]) && q.sio_oe_n == OE_SINGLE)
    else $error("single byte start wrong");

  a_quad_first: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    pins_fall.sclk && !pins_lvl.cs_n && q.phase == PH_DATA && !q.soft_rst
    && q.out_left == '0 && four_line_command_mode_in
    |=> q.sio_out == $past(rom_byte[7:4]) && q.sio_oe_n == OE_QUAD)
    else $error("quad byte start wrong");

  a_addr_advance: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    pins_fall.sclk && !pins_lvl.cs_n && q.phase == PH_DATA && !q.soft_rst && q.out_left == '0
    |=> q.addr == $past(q.addr) + ADDR_ONE)
    else $error("read address did not advance");

  a_quad_lanes: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    four_line_command_mode_in && q.sio_oe_n != OE_ALL_OFF |-> q.sio_oe_n == OE_QUAD)
    else $error("partial lanes driven in quad mode");

  c_soft_reset: cover property (@(posedge ref_clk_in) disable iff (rst_in)
    q.soft_rst);
  c_arm_cancel: cover property (@(posedge ref_clk_in) disable iff (rst_in)
    q.arm ##[1:400] !q.arm && !q.soft_rst);
  c_read_data: cover property (@(posedge ref_clk_in) disable iff (rst_in)
    q.phase == PH_DATA && q.sio_oe_n != OE_ALL_OFF);
  c_quad_read: cover property (@(posedge ref_clk_in) disable iff (rst_in)
    q.phase == PH_DATA && q.sio_oe_n == OE_QUAD);
  c_abort_seen: cover property (@(posedge ref_clk_in) disable iff (rst_in)
    q.abort);

endmodule

// file: test/host_link_model.sv
`timescale 1ns/10ps
module host_link_model
  import flash_cmd_pkg::*;
(
  input  wire logic       ref_clk_in,
  input  wire logic       quad_in,
  input  wire logic [3:0] sio_in,
  output logic            cs_n_out,
  output logic            sclk_out,
  output logic [3:0]      sio_out
);
  logic [63:0] rx_q;
  logic [3:0]  junk_q;

  // Idle pins: select high, link clock parked low
  initial begin
    cs_n_out = 1'b1;
    sclk_out = 1'b0;
    sio_out  = 4'h0;
    junk_q   = 4'h5;
    rx_q     = '0;
  end

  task automatic wait_clk(input int n);
    repeat (n) @(negedge ref_clk_in);
  endtask

  // ----------------------------------------
  // One framed transfer, 80 ns link clock
  // ----------------------------------------
  // Shifts w out MSB first for hdr_clk clocks, then reads for out_clk clocks;
  // read data is taken just before each fall, when it has long settled
  task automatic frame(input logic [39:0] w, input int hdr_clk, input int out_clk);
    logic [39:0] s;
    s = w;
    wait_clk(1);
    cs_n_out = 1'b0;
    for (int k = 0; k < hdr_clk + out_clk; k++) begin
      junk_q = ~junk_q;
      sclk_out = 1'b0;
      if (k >= hdr_clk) begin
        sio_out = junk_q;                     // Released lines keep changing
      end else if (quad_in) begin
        sio_out = s[39:36];
        s = s << 4;
      end else begin
        sio_out = {junk_q[3:1], s[39]};       // upper lines are noise
        s = s << 1;
      end
      wait_clk(4);
      sclk_out = 1'b1;
      wait_clk(4);
      if (quad_in) rx_q = {rx_q[59:0], sio_in};
      else rx_q = {rx_q[62:0], sio_in[1]};
    end
    sclk_out = 1'b0;
    wait_clk(4);
    cs_n_out = 1'b1;                          // may end at any clock
    sio_out = ~sio_out;
    wait_clk(8);                              // Gap between frames
  endtask
endmodule

// file: test/flash_reset_and_sfdp_read_bench.sv
`timescale 1ns/10ps
module flash_reset_and_sfdp_read_bench;
  import flash_cmd_pkg::*;

  localparam logic [7:0] EXP_TAB [28] = '{
    8'h53, 8'h46, 8'h44, 8'h50, 8'h00, 8'h01, 8'h01, 8'hFF,
    8'h00, 8'h00, 8'h01, 8'h09, 8'h30, 8'h00, 8'h00, 8'hFF,
    8'h3E, 8'h00, 8'h01, 8'h04, 8'h60, 8'h00, 8'h00, 8'hFF,  // 10h: arbitrary maker code
    8'hFF, 8'hFF, 8'hFF, 8'hFF};

  logic       ref_clk_in;
  logic       rst_in;
  logic       quad;
  logic       pgm_busy;
  logic       ers_busy;
  logic       cs_n;
  logic       sclk;
  logic [3:0] host_sio;
  logic [3:0] sio_wire;
  logic [3:0] sio_out;
  logic [3:0] oe_n;
  logic       soft_rst;
  logic       abort;
  logic       recov;
  logic       standby;
  logic       cs_prev  = 1'b1;
  logic [3:0] oe_frame = 4'hF;
  int         fails;
  int         checked;
  int         n_rst    = 0;
  int         n_abort  = 0;
  int         rec_len  = 0;

  flash_cmd_core i_flash_cmd_core (
    .ref_clk_in(ref_clk_in), .rst_in(rst_in), .link_cs_n_in(cs_n), .link_sclk_in(sclk),
    .link_sio_in(sio_wire), .four_line_command_mode_in(quad), .program_busy_in(pgm_busy),
    .erase_busy_in(ers_busy), .link_sio_out(sio_out), .link_sio_oe_n_out(oe_n),
    .soft_reset_out(soft_rst), .op_abort_out(abort), .recovery_busy_out(recov),
    .standby_out(standby));

  host_link_model i_host_link_model (
    .ref_clk_in(ref_clk_in), .quad_in(quad), .sio_in(sio_wire), .cs_n_out(cs_n),
    .sclk_out(sclk), .sio_out(host_sio));

  // Wire level: the device wins on every line it enables
  always_comb begin
    for (int i = 0; i < 4; i++) sio_wire[i] = oe_n[i] ? host_sio[i] : sio_out[i];
  end

  initial begin
    ref_clk_in = 1'b0;
    forever #5 ref_clk_in = ~ref_clk_in;
  end

  // Pulse counters, recovery length and enables seen within the last frame
  always @(posedge ref_clk_in) begin
    if (soft_rst === 1'b1) n_rst <= n_rst + 1;
    if (abort === 1'b1) n_abort <= n_abort + 1;
    if (recov === 1'b1) rec_len <= rec_len + 1;
    if (cs_prev && !cs_n) oe_frame <= 4'hF;
    else if (!cs_n) oe_frame <= oe_frame & oe_n;
    cs_prev <= cs_n;
  end

  task automatic tally_and_finish;
    if (fails == 0 && checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic cmp8(input string what, input logic [7:0] exp, input logic [7:0] got);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_idle;
    cmp8("standby", 8'h01, {7'h0, standby});
    cmp8("enables idle", {4'h0, OE_ALL_OFF}, {4'h0, oe_n});
  endtask

  task automatic t_read_single;
    logic [7:0] got;
    for (int a = 0; a < 28; a += 4) begin
      i_host_link_model.frame({PARAM_TABLE_READ_CMD, 24'(a), 8'h00}, 40, 32);
      cmp8("single enables", {4'h0, OE_SINGLE}, {4'h0, oe_frame});
      for (int b = 0; b < 4; b++) begin
        got = i_host_link_model.rx_q[31-8*b -: 8];
        cmp8("table byte", EXP_TAB[a+b], got);
      end
    end
  endtask

  task automatic t_read_quad;
    quad = 1'b1;
    i_host_link_model.frame({PARAM_TABLE_READ_CMD, 24'h00_0008, 8'h00}, 10, 16);
    cmp8("quad enables", {4'h0, OE_QUAD}, {4'h0, oe_frame});
    for (int b = 0; b < 8; b++)
      cmp8("quad byte", EXP_TAB[8+b], i_host_link_model.rx_q[63-8*b -: 8]);
    quad = 1'b0;
  endtask

  task automatic t_read_abort;
    i_host_link_model.frame({PARAM_TABLE_READ_CMD, 24'h00_000C, 8'h00}, 40, 3);
    cmp8("partial bits", 8'h01, {5'h0, i_host_link_model.rx_q[2:0]});
    cmp8("enables off", {4'h0, OE_ALL_OFF}, {4'h0, oe_n});
  endtask

  // Every arm is spoilt before or by its execute, so no reset may happen
  task automatic t_no_reset;
    logic [39:0] mid [3];
    int n0;
    mid = '{{NOP_CMD, 32'h0}, {PARAM_TABLE_READ_CMD, 32'h0}, {8'h3C, 32'h0}};
    n0 = n_rst;
    i_host_link_model.frame({RESET_EXEC_CMD, 32'h0}, 8, 0);
    for (int i = 0; i < 3; i++) begin
      i_host_link_model.frame({RESET_ARM_CMD, 32'h0}, 8, 0);
      i_host_link_model.frame(mid[i], i == 1 ? 12 : 8, 0);
      i_host_link_model.frame({RESET_EXEC_CMD, 32'h0}, 8, 0);
    end
    i_host_link_model.frame({RESET_ARM_CMD, 32'h0}, 8, 0);
    i_host_link_model.frame({RESET_EXEC_CMD, 32'h0}, 9, 0);    // extra clock
    cmp8("reset pulses", 8'h00, 8'(n_rst - n0));
    cmp8("standby kept", 8'h01, {7'h0, standby});
  endtask

  task automatic t_soft_reset(input logic pgm, input logic ers, input logic q,
                              input int exp_cyc, input int exp_abort);
    int n0;
    int a0;
    int w;
    int r0;
    logic ok;
    n0 = n_rst;
    a0 = n_abort;
    r0 = rec_len;
    quad = q;
    pgm_busy = pgm;
    ers_busy = ers;
    i_host_link_model.frame({RESET_ARM_CMD, 32'h0}, q ? 2 : 8, 0);
    i_host_link_model.frame({RESET_EXEC_CMD, 32'h0}, q ? 2 : 8, 0);
    cmp8("standby in recovery", 8'h00, {7'h0, standby});
    quad = 1'b0;
    pgm_busy = 1'b0;
    ers_busy = 1'b0;
    i_host_link_model.frame({RESET_ARM_CMD, 32'h0}, 8, 0);          // ignored while busy
    w = 0;
    while (recov !== 1'b0 && w < 5000) begin
      @(negedge ref_clk_in);
      w++;
    end
    if (recov !== 1'b0) begin
      fails++;
      tally_and_finish;
    end
    i_host_link_model.frame({RESET_EXEC_CMD, 32'h0}, 8, 0);         // busy arm was void
    ok = (rec_len - r0 >= exp_cyc - 2) && (rec_len - r0 <= exp_cyc + 2);
    cmp8("recovery length ok", 8'h01, {7'h0, ok});
    cmp8("reset pulses", 8'h01, 8'(n_rst - n0));
    cmp8("abort pulses", 8'(exp_abort), 8'(n_abort - a0));
    cmp8("standby after", 8'h01, {7'h0, standby});
  endtask

  initial begin
    rst_in = 1'b1;
    quad = 1'b0;
    pgm_busy = 1'b0;
    ers_busy = 1'b0;
    fails = 0;
    checked = 0;
    repeat (8) @(negedge ref_clk_in);
    rst_in = 1'b0;
    repeat (4) @(negedge ref_clk_in);
    t_idle;
    t_read_single;
    t_read_quad;
    t_read_abort;
    t_no_reset;
    t_soft_reset(1'b1, 1'b0, 1'b0, int'(RECOV_PGM_CYC), 1);
    t_soft_reset(1'b0, 1'b1, 1'b1, int'(RECOV_OTHER_CYC), 1);
    t_soft_reset(1'b0, 1'b0, 1'b0, int'(RECOV_OTHER_CYC), 0);
    t_idle;
    tally_and_finish;
  end
endmodule
